// file: lae_pkg.sv
// Constants shared by the line alarm status and enable register bank.
package lae_pkg;
  // Avalon word address: channel select in the high nibble, sub-address in the low nibble.
  localparam int ADDR_W = 8;
  localparam int SUB_W = 4;
  localparam int CH_LSB = 4;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 8;
  localparam int NUM_SRC = 7;
  localparam int SYNC_STAGES = 2;
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] SUB_STATUS = 4'h2;
  localparam logic [3:0] SUB_ENABLE = 4'h3;
  localparam logic [3:0] SUB_CHAN_IEN = 4'h4;
  localparam logic [3:0] SUB_IRQ_STAT = 4'h5;
  localparam logic [3:0] SUB_IRQ_MASK = 4'h6;
  localparam logic [3:0] SUB_MODE = 4'h7;
  // Status register fields.
  localparam int ST_RED = 7;
  localparam int ST_AIS = 6;
  localparam int ST_CAS = 5;
  localparam int ST_LOS = 4;
  localparam int ST_BPV = 3;
  localparam int ST_REDC = 2;
  localparam int ST_AISC = 1;
  localparam int ST_YEL = 0;
  localparam int NUM_FLAGS = 6;
  localparam int NUM_EN = 5;
  // Channel interrupt enable, interrupt status and mode fields.
  localparam int IEN_ALARM = 1;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_LOF = 1;
  localparam int MODE_E1 = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
endpackage : lae_pkg

// file: lae_sync.sv
// Two-stage synchroniser for a vector of independent levels.
`timescale 1ns/1ns
module lae_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : lae_sync

// file: lae_flags.sv
// Vector of sticky flags where a set in the same cycle beats a clear.
`timescale 1ns/1ns
module lae_flags #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= (q & ~clr) | set;
    end
  end
endmodule : lae_flags

// file: lae_alarm_bank.sv
// Per-channel receive alarm status and interrupt enable registers on Avalon-MM.
//
// Overview of operation
// - Status bit 7 shows the live red alarm state of the channel.
// - Status bit 6 shows the live AIS state of the channel.
// - In E1 mode status bit 5 latches a change of the CAS multiframe yellow alarm state.
// - Status bit 4 latches any change of the loss-of-signal state.
// - Status bit 3 latches any change of the bipolar violation state.
// - Status bit 2 latches any change of the red alarm state.
// - Status bit 1 latches any change of the AIS state.
// - Status bit 0 latches any change of the yellow alarm state.
// - Status sits at sub-address 0x02 and enable at 0x03 in the block chosen by the channel nibble.
// - Enable bits 4 to 0 are read/write enables for the five change flags, bits 7 to 5 read zero.
// - Enable bit 3 gates the bipolar violation change flag onto the interrupt.
// - A flag raises an interrupt on each event only while its enable bit is one.
// - With the red alarm change enable set, a loss-of-frame detection raises the frame loss interrupt.
// - All interrupts of this group are gated by bit 1 of the channel interrupt enable register.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
module lae_alarm_bank #(
  parameter int CH = lae_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [lae_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [lae_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [lae_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [CH-1:0] rx_red_alarm,
  input wire logic [CH-1:0] rx_ais,
  input wire logic [CH-1:0] rx_cas_mf_yellow,
  input wire logic [CH-1:0] rx_los,
  input wire logic [CH-1:0] rx_bpv,
  input wire logic [CH-1:0] rx_yellow,
  input wire logic [CH-1:0] rx_lof,
  output logic [CH-1:0] rx_frame_loss_irq,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////////
  // Alarm inputs come from the framer's receive clock and are synchronised.

  logic [lae_pkg::NUM_SRC*CH-1:0] raw;
  logic [lae_pkg::NUM_SRC*CH-1:0] syn;
  logic [CH-1:0] s_red;
  logic [CH-1:0] s_ais;
  logic [CH-1:0] s_cas;
  logic [CH-1:0] s_los;
  logic [CH-1:0] s_bpv;
  logic [CH-1:0] s_yel;
  logic [CH-1:0] s_lof;

  assign raw = {rx_lof, rx_yellow, rx_bpv, rx_los, rx_cas_mf_yellow, rx_ais, rx_red_alarm};
  assign {s_lof, s_yel, s_bpv, s_los, s_cas, s_ais, s_red} = syn;

  lae_sync #(
    .W(lae_pkg::NUM_SRC * CH)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(raw),
    .q(syn)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Avalon slave: with ce high every access waits exactly one cycle, then is accepted.

  logic ack;
  logic req;
  logic accept;
  logic rd_accept;
  logic wr_accept;
  logic [lae_pkg::SUB_W-1:0] sub;
  logic [lae_pkg::ADDR_W-lae_pkg::CH_LSB-1:0] chsel;
  logic [7:0] rd_byte;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign accept = req & ack & ce;
  assign rd_accept = accept & avs_read;
  assign wr_accept = accept & avs_write & avs_byteenable[0];
  assign sub = avs_address[lae_pkg::SUB_W-1:0];
  assign chsel = avs_address[lae_pkg::ADDR_W-1:lae_pkg::CH_LSB];

  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= req & ~ack;
    end
  end

  logic [7:0] stat_b [CH];
  logic [7:0] en_b [CH];
  logic [7:0] ien_b [CH];
  logic [7:0] istat_b [CH];
  logic [7:0] imask_b [CH];
  logic [7:0] mode_b [CH];
  logic [CH-1:0] pend;

  // Read data is captured in the waiting cycle, so the clear-on-read below can
  // clear exactly the flags that software is shown and lose no later event.
  always_comb begin
    rd_byte = lae_pkg::RST_BYTE;
    for (int c = 0; c < CH; c++) begin
      if (chsel == c[lae_pkg::ADDR_W-lae_pkg::CH_LSB-1:0]) begin
        case (sub)
          lae_pkg::SUB_STATUS: rd_byte = stat_b[c];
          lae_pkg::SUB_ENABLE: rd_byte = en_b[c];
          lae_pkg::SUB_CHAN_IEN: rd_byte = ien_b[c];
          lae_pkg::SUB_IRQ_STAT: rd_byte = istat_b[c];
          lae_pkg::SUB_IRQ_MASK: rd_byte = imask_b[c];
          lae_pkg::SUB_MODE: rd_byte = mode_b[c];
          default: rd_byte = lae_pkg::RST_BYTE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= lae_pkg::RD_UNMAPPED;
    end else if (ce && avs_read && !ack) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel registers, change detection and interrupt sources.

  for (genvar c = 0; c < CH; c++) begin : g_ch
    logic hit;
    logic [lae_pkg::NUM_FLAGS-1:0] cur;
    logic [lae_pkg::NUM_FLAGS-1:0] prev;
    logic primed;
    logic [lae_pkg::NUM_FLAGS-1:0] chg;
    logic [lae_pkg::NUM_FLAGS-1:0] fset;
    logic [lae_pkg::NUM_FLAGS-1:0] fclr;
    logic [lae_pkg::NUM_FLAGS-1:0] flg;
    logic [lae_pkg::NUM_EN-1:0] en;
    logic ien;
    logic e1;
    logic [1:0] imask;
    logic [1:0] iset;
    logic [1:0] iclr;
    logic [1:0] istat;
    logic lof_prev;

    assign hit = (chsel == (lae_pkg::ADDR_W-lae_pkg::CH_LSB)'(c));
    assign cur = {s_cas[c], s_los[c], s_bpv[c], s_red[c], s_ais[c], s_yel[c]};

    // The first sample after reset only primes the history, but the synchroniser still reads zero then, so
    // a line that is already in alarm at reset is reported as a change once its level comes through.
    always_ff @(posedge clk) begin
      if (rst) begin
        prev <= '0;
        primed <= 1'b0;
        lof_prev <= 1'b0;
      end else if (ce) begin
        prev <= cur;
        primed <= 1'b1;
        lof_prev <= s_lof[c];
      end
    end

    assign chg = (cur ^ prev) & {lae_pkg::NUM_FLAGS{primed}};
    // The CAS multiframe flag only exists in E1 mode.
    assign fset = chg & {e1, {(lae_pkg::NUM_FLAGS-1){1'b1}}};
    assign fclr = (wr_accept && hit && sub == lae_pkg::SUB_STATUS) ? '1 :
                  (rd_accept && hit && sub == lae_pkg::SUB_STATUS) ?
                  avs_readdata[lae_pkg::NUM_FLAGS-1:0] : '0;

    lae_flags #(
      .W(lae_pkg::NUM_FLAGS)
    ) u_chg (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .set(fset),
      .clr(fclr),
      .q(flg)
    );

    always_ff @(posedge clk) begin
      if (rst) begin
        en <= '0;
      end else if (ce && wr_accept && hit && sub == lae_pkg::SUB_ENABLE) begin
        en <= avs_writedata[lae_pkg::NUM_EN-1:0];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        ien <= 1'b0;
        imask <= '0;
        e1 <= 1'b0;
      end else if (ce && wr_accept && hit) begin
        if (sub == lae_pkg::SUB_CHAN_IEN) begin
          ien <= avs_writedata[lae_pkg::IEN_ALARM];
        end
        if (sub == lae_pkg::SUB_IRQ_MASK) begin
          imask <= avs_writedata[1:0];
        end
        if (sub == lae_pkg::SUB_MODE) begin
          e1 <= avs_writedata[lae_pkg::MODE_E1];
        end
      end
    end

    // Each enabled change raises the group event; bit 3 covers bipolar violations.
    assign iset[lae_pkg::IRQ_ALARM] = |(chg[lae_pkg::NUM_EN-1:0] & en);
    assign iset[lae_pkg::IRQ_LOF] = s_lof[c] & ~lof_prev & primed & en[lae_pkg::ST_REDC];
    assign iclr = (wr_accept && hit && sub == lae_pkg::SUB_IRQ_STAT) ? avs_writedata[1:0] : 2'b00;

    lae_flags #(
      .W(2)
    ) u_irq (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .set(iset),
      .clr(iclr),
      .q(istat)
    );

    // In T1 mode bit 5 shows the live yellow state instead of a change flag.
    assign stat_b[c] = {s_red[c], s_ais[c], e1 ? flg[lae_pkg::ST_CAS] : s_yel[c],
                        flg[lae_pkg::NUM_EN-1:0]};
    assign en_b[c] = {3'h0, en};
    assign ien_b[c] = {6'h00, ien, 1'b0};
    assign istat_b[c] = {6'h00, istat};
    assign imask_b[c] = {6'h00, imask};
    assign mode_b[c] = {7'h00, e1};
    assign pend[c] = ien & |(istat & imask);
    assign rx_frame_loss_irq[c] = ien & istat[lae_pkg::IRQ_LOF] & imask[lae_pkg::IRQ_LOF];
  end

  assign irq = |pend;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on channel 0; the reserved enable bit check covers every channel.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic rd0_stat;
  assign rd0_stat = rd_accept && chsel == '0 && sub == lae_pkg::SUB_STATUS;

  property p_red_live;
    ce && $past(ce) && $past(ce, 2) |-> stat_b[0][lae_pkg::ST_RED] == $past(rx_red_alarm[0], 2);
  endproperty
  a_red_live: assert property (p_red_live) else $error("red live bit wrong");

  property p_ais_live;
    ce && $past(ce) && $past(ce, 2) |-> stat_b[0][lae_pkg::ST_AIS] == $past(rx_ais[0], 2);
  endproperty
  a_ais_live: assert property (p_ais_live) else $error("AIS live bit wrong");

  property p_cas_chg;
    ce && g_ch[0].e1 && g_ch[0].chg[lae_pkg::ST_CAS] |=> stat_b[0][lae_pkg::ST_CAS];
  endproperty
  a_cas_chg: assert property (p_cas_chg) else $error("CAS change not latched");

  property p_los_chg;
    ce && g_ch[0].chg[lae_pkg::ST_LOS] |=> g_ch[0].flg[lae_pkg::ST_LOS];
  endproperty
  a_los_chg: assert property (p_los_chg) else $error("LOS change not latched");

  property p_ais_chg;
    ce && g_ch[0].chg[lae_pkg::ST_AISC] |=> g_ch[0].flg[lae_pkg::ST_AISC];
  endproperty
  a_ais_chg: assert property (p_ais_chg) else $error("AIS change not latched");

  property p_yel_chg;
    ce && g_ch[0].chg[lae_pkg::ST_YEL] |=> g_ch[0].flg[lae_pkg::ST_YEL];
  endproperty
  a_yel_chg: assert property (p_yel_chg) else $error("yellow change not latched");

  property p_red_chg;
    ce && $changed(s_red[0]) && g_ch[0].primed && $past(ce) |=> g_ch[0].flg[lae_pkg::ST_REDC];
  endproperty
  a_red_chg: assert property (p_red_chg) else $error("red change not latched");

  property p_flag_cause;
    ce && $rose(g_ch[0].flg[lae_pkg::ST_BPV]) |-> $past(g_ch[0].chg[lae_pkg::ST_BPV]);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("BPV flag set without change");

  // Only the flags that were shown are cleared; a flag set after the capture survives.
  property p_rd_clear;
    rd0_stat && g_ch[0].chg == '0
      |=> (g_ch[0].flg[lae_pkg::NUM_EN-1:0] & $past(avs_readdata[lae_pkg::NUM_EN-1:0])) == '0;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared by read");

  property p_rd_status;
    rd0_stat && $past(ce) |-> avs_readdata[7:0] == $past(stat_b[0]);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read data wrong");

  property p_en_resv;
    rd_accept && sub == lae_pkg::SUB_ENABLE |-> avs_readdata[7:lae_pkg::NUM_EN] == '0;
  endproperty
  a_en_resv: assert property (p_en_resv) else $error("reserved enable bits set");

  property p_en_write;
    ce && wr_accept && chsel == '0 && sub == lae_pkg::SUB_ENABLE
      |=> g_ch[0].en == $past(avs_writedata[lae_pkg::NUM_EN-1:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_irq_cause;
    ce && $rose(g_ch[0].istat[lae_pkg::IRQ_ALARM]) |-> $past(|(g_ch[0].chg[4:0] & g_ch[0].en));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without enabled event");

  property p_irq_set;
    ce && g_ch[0].chg[lae_pkg::ST_BPV] && g_ch[0].en[lae_pkg::ST_BPV] |=> g_ch[0].istat[lae_pkg::IRQ_ALARM];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("enabled event lost");

  property p_lof_irq;
    ce && g_ch[0].iset[lae_pkg::IRQ_LOF] |=> g_ch[0].istat[lae_pkg::IRQ_LOF];
  endproperty
  a_lof_irq: assert property (p_lof_irq) else $error("frame loss not latched");

  property p_group_gate;
    rx_frame_loss_irq[0] |-> g_ch[0].ien && g_ch[0].en[lae_pkg::ST_REDC] | $past(g_ch[0].istat[1]);
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("frame loss irq not gated");

  property p_reset_clear;
    $past(rst) |-> stat_b[0][5:0] == '0 && en_b[0] == lae_pkg::RST_BYTE && !irq;
  endproperty
  a_reset_clear: assert property (@(posedge clk) p_reset_clear) else $error("reset value wrong");

  c_read_status: cover property (rd0_stat && avs_readdata[lae_pkg::ST_LOS]);
  c_irq_raise: cover property (ce && $rose(irq));
  c_set_beats_clear: cover property (rd0_stat && g_ch[0].chg[lae_pkg::ST_YEL]);
  c_lof: cover property ($rose(rx_frame_loss_irq[0]));
endmodule : lae_alarm_bank

// file: lae_rx_alarm_model.sv
// Behavioural model of the receive framer alarm detectors feeding the alarm bank.
`timescale 1ns/1ns
module lae_rx_alarm_model #(
  parameter int CH = 8
) (
  input wire logic clk,
  output logic [CH-1:0] rx_yellow,
  output logic [CH-1:0] rx_ais,
  output logic [CH-1:0] rx_red_alarm,
  output logic [CH-1:0] rx_bpv,
  output logic [CH-1:0] rx_los,
  output logic [CH-1:0] rx_cas_mf_yellow,
  output logic [CH-1:0] rx_lof
);
  logic [CH-1:0] lvl [7];
  initial begin
    for (int i = 0; i < 7; i++) begin
      lvl[i] = '0;
    end
  end
  assign rx_yellow = lvl[0];
  assign rx_ais = lvl[1];
  assign rx_red_alarm = lvl[2];
  assign rx_bpv = lvl[3];
  assign rx_los = lvl[4];
  assign rx_cas_mf_yellow = lvl[5];
  assign rx_lof = lvl[6];
  // Detector levels move only just after a clock edge, like a registered detector would.
  task automatic flip(input int src, input int ch);
    @(posedge clk);
    lvl[src][ch] <= ~lvl[src][ch];
  endtask : flip
endmodule : lae_rx_alarm_model

// file: testbench.sv
// Self-checking testbench for the receive alarm status and enable register bank.
`timescale 1ns/1ns
module testbench;
  localparam int CH = 8;
  localparam logic [3:0] C = 4'h0;
  logic clk, rst;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq;
  logic [31:0] avs_writedata, avs_readdata;
  logic [CH-1:0] rx_red_alarm, rx_ais, rx_cas_mf_yellow, rx_los, rx_bpv, rx_yellow, rx_lof, rx_frame_loss_irq;
  logic [7:0] d;
  logic lv [7];
  int n_mismatch = 0;
  int cmp_count = 0;

  lae_alarm_bank #(.CH(CH)) DUT (.clk(clk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_red_alarm(rx_red_alarm),
    .rx_ais(rx_ais), .rx_cas_mf_yellow(rx_cas_mf_yellow), .rx_los(rx_los), .rx_bpv(rx_bpv),
    .rx_yellow(rx_yellow), .rx_lof(rx_lof), .rx_frame_loss_irq(rx_frame_loss_irq), .irq(irq));

  lae_rx_alarm_model #(.CH(CH)) model (.clk(clk), .rx_yellow(rx_yellow), .rx_ais(rx_ais),
    .rx_red_alarm(rx_red_alarm), .rx_bpv(rx_bpv), .rx_los(rx_los), .rx_cas_mf_yellow(rx_cas_mf_yellow),
    .rx_lof(rx_lof));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The request is held until waitrequest is sampled low; only the watchdog ends a stuck wait.
  task automatic bus(input logic wr, input logic [3:0] ch, input logic [3:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk);
    avs_address <= {ch, idx};
    avs_writedata <= {24'h000000, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
    logic [7:0] x;
    bus(1'b1, C, idx, wd, x);
  endtask : wr

  task automatic flip(input int s);
    model.flip(s, C);
    lv[s] = ~lv[s];
    repeat (6) @(posedge clk);
  endtask : flip

  task automatic irq_is(input logic [7:0] exp);
    @(negedge clk);
    check("irq", {7'h00, irq}, exp);
  endtask : irq_is

  function automatic logic [7:0] live();
    return {lv[2], lv[1], 6'h00};
  endfunction : live

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    for (int i = 0; i < 7; i++) begin
      lv[i] = 1'b0;
    end
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, C, lae_pkg::SUB_STATUS, 8'h00, d);
    check("status reset", d, 8'h00);
    bus(1'b0, C, lae_pkg::SUB_ENABLE, 8'h00, d);
    check("enable reset", d, 8'h00);
    bus(1'b0, C, 4'h9, 8'h00, d);
    check("unmapped", d, 8'h00);
    wr(lae_pkg::SUB_ENABLE, 8'hff);
    bus(1'b0, C, lae_pkg::SUB_ENABLE, 8'h00, d);
    check("enable rw", d, 8'h1f);
    wr(lae_pkg::SUB_ENABLE, 8'h00);
    wr(lae_pkg::SUB_MODE, 8'h01);
    // Each source but rx_lof is entered and then left, so each flag sees both directions of change.
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 6; s++) begin
        flip(s);
        bus(1'b0, C, lae_pkg::SUB_STATUS, 8'h00, d);
        check("flag set", d, live() | (8'h01 << s));
        bus(1'b0, C, lae_pkg::SUB_STATUS, 8'h00, d);
        check("flag read clear", d, live());
      end
    end
    bus(1'b0, 4'h1, lae_pkg::SUB_STATUS, 8'h00, d);
    check("other channel", d, 8'h00);
    flip(2);
    wr(lae_pkg::SUB_STATUS, 8'h00);
    bus(1'b0, C, lae_pkg::SUB_STATUS, 8'h00, d);
    check("flag write clear", d, live());
    // In T1 mode bit 5 shows the live yellow state and a CAS change is not latched.
    wr(lae_pkg::SUB_MODE, 8'h00);
    flip(0);
    flip(5);
    bus(1'b0, C, lae_pkg::SUB_STATUS, 8'h00, d);
    check("t1 status", d, 8'ha1);
    bus(1'b0, C, lae_pkg::SUB_STATUS, 8'h00, d);
    check("t1 read clear", d, 8'ha0);
    wr(lae_pkg::SUB_CHAN_IEN, 8'h02);
    wr(lae_pkg::SUB_IRQ_MASK, 8'h03);
    wr(lae_pkg::SUB_ENABLE, 8'h08);
    flip(0);
    irq_is(8'h00);
    flip(3);
    irq_is(8'h01);
    bus(1'b0, C, lae_pkg::SUB_IRQ_STAT, 8'h00, d);
    check("irq status", d, 8'h01);
    wr(lae_pkg::SUB_IRQ_STAT, 8'h01);
    irq_is(8'h00);
    wr(lae_pkg::SUB_CHAN_IEN, 8'h00);
    flip(3);
    irq_is(8'h00);
    wr(lae_pkg::SUB_CHAN_IEN, 8'h02);
    irq_is(8'h01);
    wr(lae_pkg::SUB_IRQ_MASK, 8'h02);
    irq_is(8'h00);
    wr(lae_pkg::SUB_IRQ_MASK, 8'h03);
    wr(lae_pkg::SUB_IRQ_STAT, 8'h01);
    wr(lae_pkg::SUB_ENABLE, 8'h04);
    flip(6);
    @(negedge clk);
    check("frame loss", rx_frame_loss_irq, 8'h01 << C);
    bus(1'b0, C, lae_pkg::SUB_IRQ_STAT, 8'h00, d);
    check("frame loss status", d, 8'h02);
    wr(lae_pkg::SUB_IRQ_STAT, 8'h02);
    flip(6);
    @(negedge clk);
    check("frame loss fall", rx_frame_loss_irq, 8'h00);
    irq_is(8'h00);
    results();
  end
endmodule : testbench
